// >>> logic/arm_regs.sv
// rate, motion control and sample fifo register bank with fifo storage
`timescale 1ns/1ps
`default_nettype none
module arm_regs (
  input  wire logic                   clk,
  input  wire logic                   srst,
  // register port
  input  wire logic                   reg_wr_en,
  input  wire logic                   reg_rd_en,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata,
  output logic                        reg_rd_valid,
  // operating state and fifo enable
  input  wire logic                   wake_state,
  input  wire logic                   fifo_enable,
  // sample stream from the front end
  input  wire logic                   smp_valid,
  output logic                        smp_ready,
  input  wire arm_pkg::arm_sample_t   smp_data,
  // motion detector outputs, bit order tilt, flip, anym, shake, tilt35
  input  wire logic [4:0]             det_raw,
  input  wire logic [4:0]             det_filt,
  // configuration outputs
  output logic [2:0]                  output_sample_rate,
  output logic [10:0]                 rate_hz,
  output arm_pkg::arm_motion_cfg_t    motion_cfg,
  output logic [4:0]                  motion_flags,
  // fifo condition
  output logic                        queue_empty,
  output logic                        queue_full,
  output logic                        queue_level_flag
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]                rate_ff;       // rate register byte
  arm_pkg::arm_motion_cfg_t  motion_ff;     // motion control byte
  logic [5:0]                queue_read_index;
  logic [5:0]                queue_write_index;
  logic [5:0]                rd_idx_ff;     // read index with wrap
  logic [5:0]                wr_idx_ff;     // write index with wrap
  logic [5:0]                fill_level;    // entries held
  logic [47:0]               mem_ff [arm_pkg::QDEPTH]; // sample storage
  logic [47:0]               last_ff;       // latest sample, fifo off
  logic [47:0]               head_word;     // word shown to reads
  arm_pkg::arm_rd_seq_t      seq_ff;        // read burst tracker
  arm_pkg::arm_rd_seq_t      nxt_seq;
  logic                      pop_evt;       // completed sample read
  logic                      buf_valid;
  logic                      buf_ready;
  arm_pkg::arm_sample_t      buf_data;
  logic                      store_evt;     // sample written
  logic [15:0]               z_adj;         // z after polarity
  logic [4:0]                feat_en;       // per-flag enables
  logic [4:0]                flag_src;      // raw or filtered
  logic [7:0]                qflags;        // live flag byte
  logic [7:0]                nxt_rdata;
  logic                      rd_hit;

  // ----------------------------------------------------------------
  // sample path buffer
  // ----------------------------------------------------------------
  arm_pair_buf #(
    .WIDTH     ($bits(arm_pkg::arm_sample_t))
  ) u_buf (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .in_data   (smp_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  // drain only in wake, stall while the enabled fifo is full
  assign buf_ready = wake_state && !(fifo_enable && queue_full);
  // only samples with a completed z conversion are stored
  assign store_evt = buf_valid && buf_ready && buf_data.z_ok;
  // z sign follows the polarity bit
  assign z_adj = motion_ff.vertical_axis_polarity ? 16'(-buf_data.z) : buf_data.z;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // rate register keeps the whole byte as written
  always_ff @(posedge clk) begin
    if (srst) begin
      rate_ff <= arm_pkg::RST_RATE;
    end else if (reg_wr_en && reg_addr == arm_pkg::ADDR_RATE) begin
      rate_ff <= reg_wdata;
    end
  end

  // motion control, reset bit stays until host rewrites it
  always_ff @(posedge clk) begin
    if (srst) begin
      motion_ff <= arm_pkg::RST_MOTION;
    end else if (reg_wr_en && reg_addr == arm_pkg::ADDR_MOTION) begin
      motion_ff <= reg_wdata;
    end
  end

  // rate decode drives oscillator and sampling rate
  assign output_sample_rate = rate_ff[arm_pkg::RATE_LSB +: arm_pkg::RATE_W];
  assign rate_hz            = arm_pkg::RATE_HZ_TBL[output_sample_rate];
  // control byte goes straight to the motion block
  assign motion_cfg         = motion_ff;

  // ----------------------------------------------------------------
  // motion flag conditioning
  // ----------------------------------------------------------------
  // shake and tilt35 only live while any-motion is on
  assign feat_en = {motion_ff.tilt35_enable & motion_ff.any_motion_enable,
                    motion_ff.shake_enable & motion_ff.any_motion_enable,
                    motion_ff.any_motion_enable,
                    motion_ff.tilt_flip_enable,
                    motion_ff.tilt_flip_enable};
  // raw detector outputs or debounced ones
  assign flag_src = motion_ff.unfiltered_flags_select ? det_raw : det_filt;

  // flags held in reset, latched or followed
  always_ff @(posedge clk) begin
    if (srst) begin
      motion_flags <= 5'h00;
    end else if (motion_ff.motion_block_reset) begin
      motion_flags <= 5'h00;
    end else if (motion_ff.motion_latch_enable) begin
      // latched flags hold until reset, clear or disable
      motion_flags <= (motion_flags | flag_src) & feat_en;
    end else begin
      motion_flags <= flag_src & feat_en;
    end
  end

  // ----------------------------------------------------------------
  // fifo indices and conditions
  // ----------------------------------------------------------------
  // write index steps once per sample stored while the fifo is enabled
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_idx_ff <= arm_pkg::RST_INDEX;
    end else if (store_evt && fifo_enable) begin
      wr_idx_ff <= wr_idx_ff + 6'd1;
    end
  end

  // read index steps once per completed sample read, wrap toggles bit 5
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_idx_ff <= arm_pkg::RST_INDEX;
    end else if (pop_evt) begin
      rd_idx_ff <= rd_idx_ff + 6'd1;
    end
  end

  // indices as read back, wrap bit included
  assign queue_read_index  = rd_idx_ff;
  assign queue_write_index = wr_idx_ff;
  // index distance, 0 to 32 entries
  assign fill_level        = wr_idx_ff - rd_idx_ff;
  // equal indices mean empty, wrap-only difference means full
  assign queue_empty = (wr_idx_ff == rd_idx_ff);
  assign queue_full  = (wr_idx_ff[4:0] == rd_idx_ff[4:0]) &&
                       (wr_idx_ff[arm_pkg::IDX_WRAP] != rd_idx_ff[arm_pkg::IDX_WRAP]);
  assign queue_level_flag = (fill_level >= arm_pkg::QLEVEL_THR);

  // live flag byte, no enable masks it
  always_comb begin
    qflags                   = 8'h00;
    qflags[arm_pkg::QF_EMPTY] = queue_empty;
    qflags[arm_pkg::QF_FULL]  = queue_full;
    qflags[arm_pkg::QF_LEVEL] = queue_level_flag;
  end

  // ----------------------------------------------------------------
  // sample storage
  // ----------------------------------------------------------------
  // fifo array written at the write address
  always_ff @(posedge clk) begin
    if (store_evt && fifo_enable) begin
      mem_ff[wr_idx_ff[4:0]] <= {buf_data.x, buf_data.y, z_adj};
    end
  end

  // latest sample for reads while the fifo is off
  always_ff @(posedge clk) begin
    if (srst) begin
      last_ff <= 48'h0000_0000_0000;
    end else if (store_evt) begin
      last_ff <= {buf_data.x, buf_data.y, z_adj};
    end
  end

  // fifo head when enabled, else the latest sample
  assign head_word = fifo_enable ? mem_ff[rd_idx_ff[4:0]] : last_ff;

  // ----------------------------------------------------------------
  // read burst tracking
  // ----------------------------------------------------------------
  // burst must start at the first byte and run in order
  always_comb begin
    nxt_seq = seq_ff;
    pop_evt = 1'b0;
    if (reg_rd_en) begin
      nxt_seq = arm_pkg::RD_IDLE;
      case (seq_ff)
        // each state waits for the next byte of the sample
        arm_pkg::RD_XH: if (reg_addr == arm_pkg::ADDR_SMP_XH) nxt_seq = arm_pkg::RD_YL;
        arm_pkg::RD_YL: if (reg_addr == arm_pkg::ADDR_SMP_YL) nxt_seq = arm_pkg::RD_YH;
        arm_pkg::RD_YH: if (reg_addr == arm_pkg::ADDR_SMP_YH) nxt_seq = arm_pkg::RD_ZL;
        arm_pkg::RD_ZL: if (reg_addr == arm_pkg::ADDR_SMP_ZL) nxt_seq = arm_pkg::RD_ZH;
        arm_pkg::RD_ZH: begin
          // last byte completes the sample
          pop_evt = (reg_addr == arm_pkg::ADDR_SMP_ZH) && fifo_enable && !queue_empty;
        end
        default: nxt_seq = arm_pkg::RD_IDLE;
      endcase
      // a first-byte read always starts a new sample
      if (reg_addr == arm_pkg::ADDR_SMP_XL) begin
        nxt_seq = arm_pkg::RD_XH;
      end
    end
  end

  // tracker state
  always_ff @(posedge clk) begin
    if (srst) begin
      seq_ff <= arm_pkg::RD_IDLE;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // read mux, write-only and unmapped bytes read zero
  always_comb begin
    nxt_rdata = 8'h00;
    rd_hit    = 1'b1;
    case (reg_addr)
      arm_pkg::ADDR_RATE:   nxt_rdata = rate_ff;
      arm_pkg::ADDR_QFLAGS: nxt_rdata = qflags;
      arm_pkg::ADDR_QRDIDX: nxt_rdata = {2'b00, queue_read_index};
      arm_pkg::ADDR_QWRIDX: nxt_rdata = {2'b00, queue_write_index};
      // x lanes, low byte first
      arm_pkg::ADDR_SMP_XL: nxt_rdata = head_word[39:32];
      arm_pkg::ADDR_SMP_XH: nxt_rdata = head_word[47:40];
      // y lanes
      arm_pkg::ADDR_SMP_YL: nxt_rdata = head_word[23:16];
      arm_pkg::ADDR_SMP_YH: nxt_rdata = head_word[31:24];
      // z lanes
      arm_pkg::ADDR_SMP_ZL: nxt_rdata = head_word[7:0];
      arm_pkg::ADDR_SMP_ZH: nxt_rdata = head_word[15:8];
      default:              rd_hit    = 1'b0;
    endcase
    // write-only control byte and holes read zero
    if (!rd_hit) begin
      nxt_rdata = 8'h00;
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      // data holds until the next read
      if (reg_rd_en) begin
        reg_rdata <= nxt_rdata;
      end
    end
  end

endmodule // arm_regs
`default_nettype wire

// >>> logic/arm_pkg.sv
// package: register map, field layout, reset values and types of the rate/motion/fifo bank
package arm_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RATE     = 8'h08; // output_rate_select
  localparam logic [7:0] ADDR_MOTION   = 8'h09; // motion_feature_control
  localparam logic [7:0] ADDR_QFLAGS   = 8'h0a; // fifo_condition_flags
  localparam logic [7:0] ADDR_QRDIDX   = 8'h0b; // fifo_read_pointer
  localparam logic [7:0] ADDR_QWRIDX   = 8'h0c; // fifo_write_pointer
  localparam logic [7:0] ADDR_SMP_XL   = 8'h0d; // first byte of a sample
  localparam logic [7:0] ADDR_SMP_XH   = 8'h0e; // x high byte
  localparam logic [7:0] ADDR_SMP_YL   = 8'h0f; // y low byte
  localparam logic [7:0] ADDR_SMP_YH   = 8'h10; // y high byte
  localparam logic [7:0] ADDR_SMP_ZL   = 8'h11; // z low byte
  localparam logic [7:0] ADDR_SMP_ZH   = 8'h12; // last byte of a sample

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RATE      = 8'h00;
  localparam logic [7:0] RST_MOTION    = 8'h00;
  localparam logic [7:0] RST_QFLAGS    = 8'h01; // empty at reset
  localparam logic [5:0] RST_INDEX     = 6'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned RATE_LSB     = 0;  // rate code bits 2:0
  localparam int unsigned RATE_W       = 3;
  localparam int unsigned QF_EMPTY     = 0;
  localparam int unsigned QF_FULL      = 1;
  localparam int unsigned QF_LEVEL     = 2;
  localparam int unsigned IDX_W        = 6;  // 5 address bits plus wrap bit
  localparam int unsigned IDX_WRAP     = 5;

  // ----------------------------------------------------------------
  // fifo geometry and level flag
  // ----------------------------------------------------------------
  localparam int unsigned QDEPTH       = 32;
  localparam logic [5:0]  QLEVEL_THR   = 6'h10; // 16 of 32 entries

  // ----------------------------------------------------------------
  // rate code to output data rate in hz, codes 7 downto 0
  // ----------------------------------------------------------------
  localparam logic [7:0][10:0] RATE_HZ_TBL = {
    11'h7d0, 11'h3e8, 11'h1f4, 11'h0fa, 11'h0c8, 11'h07d, 11'h064, 11'h032
  };

  // motion control byte, bit 7 first
  typedef struct packed {
    logic motion_block_reset;      // bit 7
    logic unfiltered_flags_select; // bit 6
    logic vertical_axis_polarity;  // bit 5
    logic tilt35_enable;           // bit 4
    logic shake_enable;            // bit 3
    logic any_motion_enable;       // bit 2
    logic motion_latch_enable;     // bit 1
    logic tilt_flip_enable;        // bit 0
  } arm_motion_cfg_t;

  // one three-axis sample from the front end
  typedef struct packed {
    logic        z_ok; // z conversion completed
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } arm_sample_t;

  // expected next byte of a sample read burst
  typedef enum logic [2:0] {
    RD_IDLE, RD_XH, RD_YL, RD_YH, RD_ZL, RD_ZH
  } arm_rd_seq_t;

endpackage : arm_pkg

// >>> logic/arm_pair_buf.sv
// two-entry valid/ready buffer in front of the sample fifo
`timescale 1ns/1ps
`default_nettype none
module arm_pair_buf #(
  parameter int unsigned WIDTH = 49
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] slot_ff [2]; // storage
  logic [1:0]       cnt_ff;      // entries held
  logic             wr_idx_ff;   // next slot to fill
  logic             rd_idx_ff;   // oldest slot
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  assign in_ready  = (cnt_ff != 2'd2);
  assign out_valid = (cnt_ff != 2'd0);
  assign out_data  = slot_ff[rd_idx_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // slot storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      slot_ff[wr_idx_ff] <= in_data;
    end
  end

  // indices and fill count
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff    <= 2'd0;
      wr_idx_ff <= 1'b0;
      rd_idx_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_idx_ff <= ~wr_idx_ff;
      end
      if (pop) begin
        rd_idx_ff <= ~rd_idx_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // arm_pair_buf
`default_nettype wire

// >>> bench/arm_regs_props.sv
// assertion checker for the rate, motion and sample fifo register bank
`timescale 1ns/1ps
`default_nettype none
module arm_regs_props (
  input wire logic                     clk,
  input wire logic                     srst,
  input wire logic                     reg_wr_en,
  input wire logic                     reg_rd_en,
  input wire logic [7:0]               reg_addr,
  input wire logic [7:0]               reg_wdata,
  input wire logic [7:0]               reg_rdata,
  input wire logic                     reg_rd_valid,
  input wire logic                     wake_state,
  input wire logic                     fifo_enable,
  input wire logic                     smp_valid,
  input wire logic                     smp_ready,
  input wire arm_pkg::arm_sample_t     smp_data,
  input wire logic [4:0]               det_raw,
  input wire logic [4:0]               det_filt,
  input wire logic [2:0]               output_sample_rate,
  input wire logic [10:0]              rate_hz,
  input wire arm_pkg::arm_motion_cfg_t motion_cfg,
  input wire logic [4:0]               motion_flags,
  input wire logic                     queue_empty,
  input wire logic                     queue_full,
  input wire logic                     queue_level_flag
);
  // ----------------------------------------------------------------
  // clocking and named request sequences
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);
  sequence rd_at(a); reg_rd_en && reg_addr == a; endsequence
  sequence wr_at(a); reg_wr_en && reg_addr == a; endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  rate_store_a: assert property (wr_at(arm_pkg::ADDR_RATE) |=>
    output_sample_rate == $past(reg_wdata[2:0])) else $error("rate code not stored");
  rate_table_a: assert property (
    rate_hz == arm_pkg::RATE_HZ_TBL[output_sample_rate]) else $error("rate decode wrong");
  motion_store_a: assert property (wr_at(arm_pkg::ADDR_MOTION) |=>
    motion_cfg == $past(reg_wdata)) else $error("motion byte not stored");
  motion_hold_a: assert property (!reg_wr_en |=> $stable(motion_cfg))
    else $error("motion byte changed without write");
  flag_read_a: assert property (rd_at(arm_pkg::ADDR_QFLAGS) |=> reg_rdata ==
    {5'h00, $past(queue_level_flag), $past(queue_full), $past(queue_empty)})
    else $error("flag read differs from live flags");
  idx_rsv_a: assert property ((rd_at(arm_pkg::ADDR_QRDIDX) or rd_at(arm_pkg::ADDR_QWRIDX))
    |=> reg_rdata[7:6] == 2'b00) else $error("index reserved bits set");
  empty_full_a: assert property (!(queue_empty && queue_full))
    else $error("empty and full together");
  level_empty_a: assert property (queue_level_flag |-> !queue_empty)
    else $error("level flag while empty");
  sleep_hold_a: assert property (queue_empty && !wake_state && $past(!wake_state)
    |=> queue_empty) else $error("sample stored while asleep");
  block_reset_a: assert property (motion_cfg.motion_block_reset [*2]
    |-> motion_flags == 5'h00) else $error("flags active in motion reset");
  reset_flags_a: assert property (disable iff (1'b0) srst |=>
    queue_empty && !queue_full) else $error("fifo flags wrong after reset");
endmodule // arm_regs_props
`default_nettype wire

// >>> bench/arm_src_model.sv
// front end model: offers numbered three-axis samples on the stream port
`timescale 1ns/1ps
`default_nettype none
module arm_src_model (
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            start,
  input  wire logic [5:0]      count,
  input  wire logic            smp_ready,
  output logic                 smp_valid,
  output arm_pkg::arm_sample_t smp_data
);
  logic [5:0] left_ff; // samples still to offer
  logic [7:0] idx_ff;  // number of the sample on offer
  arm_pkg::arm_sample_t pat; // sample pattern for idx_ff
  // count down and number samples on each handshake
  always_ff @(posedge clk) begin
    if (srst) begin
      left_ff <= 6'h00;
      idx_ff  <= 8'h00;
    end else if (start) begin
      left_ff <= count;
    end else if (smp_valid && smp_ready) begin
      left_ff <= left_ff - 6'h01;
      idx_ff  <= idx_ff + 8'h01;
    end
  end
  // z acquired flag set on every offered sample
  assign pat = {1'b1, 8'h10, idx_ff, 8'h20, idx_ff, 8'h30, idx_ff};
  assign smp_valid = (left_ff != 6'h00);
  // idle lines show the inverse pattern, never a stale value
  assign smp_data = smp_valid ? pat : ~pat;
endmodule // arm_src_model
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the rate, motion and sample fifo register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, srst, reg_wr_en, reg_rd_en, reg_rd_valid, wake_state, fifo_enable;
  logic smp_valid, smp_ready, queue_empty, queue_full, queue_level_flag, start;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [4:0] det_raw, det_filt, motion_flags;
  logic [2:0] output_sample_rate;
  logic [10:0] rate_hz;
  logic [5:0] count;
  arm_pkg::arm_sample_t smp_data;
  arm_pkg::arm_motion_cfg_t motion_cfg;
  int errors = 0;
  int checked = 0;
  // ----------------------------------------------------------------
  // design, front end model, clock
  // ----------------------------------------------------------------
  arm_regs dut_u (.clk(clk), .srst(srst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .wake_state(wake_state), .fifo_enable(fifo_enable),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data), .det_raw(det_raw),
    .det_filt(det_filt), .output_sample_rate(output_sample_rate), .rate_hz(rate_hz),
    .motion_cfg(motion_cfg), .motion_flags(motion_flags), .queue_empty(queue_empty),
    .queue_full(queue_full), .queue_level_flag(queue_level_flag));
  arm_src_model src_u (.clk(clk), .srst(srst), .start(start), .count(count),
    .smp_ready(smp_ready), .smp_valid(smp_valid), .smp_data(smp_data));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1 reg_wr_en = 1'b1; reg_addr = a; reg_wdata = d;
    @(posedge clk); #1 reg_wr_en = 1'b0;
  endtask
  // read answer is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk); #1 reg_rd_en = 1'b1; reg_addr = a;
    @(posedge clk); #1 reg_rd_en = 1'b0;
    chk("read valid", 1'b1, reg_rd_valid);
    chk(nm, exp, reg_rdata);
  endtask
  task automatic send(input logic [5:0] n);
    @(posedge clk); #1 start = 1'b1; count = n;
    @(posedge clk); #1 start = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] rst_tbl [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) rd(8'h08 + 8'(i), rst_tbl[i], "reset value");
    wr(arm_pkg::ADDR_QRDIDX, 8'hff);
    rd(arm_pkg::ADDR_QRDIDX, 8'h00, "read index after write");
    rd(8'h3f, 8'h00, "unmapped read");
    chk("empty after reset", 1'b1, queue_empty);
  endtask
  task automatic t_rate();
    int hz [8] = '{50, 100, 125, 200, 250, 500, 1000, 2000};
    for (int c = 0; c < 8; c++) begin
      wr(arm_pkg::ADDR_RATE, 8'h08 + 8'(c));
      chk("rate code", 16'(c), output_sample_rate);
      chk("rate hz", 16'(hz[c]), rate_hz);
      rd(arm_pkg::ADDR_RATE, 8'h08 + 8'(c), "rate readback");
    end
  endtask
  task automatic t_fifo();
    logic [7:0] hi [6] = '{8'h00, 8'h10, 8'h00, 8'h20, 8'h00, 8'h30};
    wake_state = 1'b0;
    send(6'h10);
    repeat (10) @(posedge clk);
    rd(arm_pkg::ADDR_QWRIDX, 8'h00, "write index asleep");
    wake_state = 1'b1;
    repeat (30) @(posedge clk);
    rd(arm_pkg::ADDR_QFLAGS, 8'h04, "flags at threshold");
    rd(arm_pkg::ADDR_QWRIDX, 8'h10, "write index 16");
    send(6'h13);
    repeat (40) @(posedge clk);
    #1 chk("buffer refuses", 1'b0, smp_ready);
    chk("sample held", 1'b1, smp_valid);
    rd(arm_pkg::ADDR_QFLAGS, 8'h06, "flags full");
    chk("full pin", 1'b1, queue_full);
    chk("level pin", 1'b1, queue_level_flag);
    rd(arm_pkg::ADDR_QWRIDX, 8'h20, "write index wrapped");
    for (int i = 0; i < 35; i++) begin
      for (int k = 0; k < 6; k++)
        rd(arm_pkg::ADDR_SMP_XL + 8'(k), k[0] ? hi[k] : 8'(i), "sample");
    end
    for (int w = 0; w < 50 && smp_valid; w++) @(posedge clk);
    if (smp_valid) begin
      errors++;
      summarize();
    end
    repeat (4) @(posedge clk);
    rd(arm_pkg::ADDR_QFLAGS, 8'h01, "flags drained");
    rd(arm_pkg::ADDR_QRDIDX, 8'h23, "read index end");
    rd(arm_pkg::ADDR_QWRIDX, 8'h23, "write index end");
  endtask
  task automatic t_motion();
    logic [22:0] tb [7] = '{{8'h45, 5'h1f, 5'h00, 5'h07}, {8'h05, 5'h1f, 5'h00, 5'h00},
      {8'h00, 5'h1f, 5'h1f, 5'h00}, {8'h1d, 5'h00, 5'h1f, 5'h1f},
      {8'h9d, 5'h00, 5'h1f, 5'h00}, {8'h07, 5'h00, 5'h04, 5'h04},
      {8'h07, 5'h00, 5'h00, 5'h04}};
    for (int i = 0; i < 7; i++) begin
      det_raw = tb[i][14:10];
      det_filt = tb[i][9:5];
      wr(arm_pkg::ADDR_MOTION, tb[i][22:15]);
      chk("motion byte", tb[i][22:15], motion_cfg);
      repeat (4) @(posedge clk);
      #1 chk("motion flags", tb[i][4:0], motion_flags);
    end
    wr(arm_pkg::ADDR_MOTION, 8'h20);
    chk("axis polarity", 1'b1, motion_cfg.vertical_axis_polarity);
    rd(arm_pkg::ADDR_MOTION, 8'h00, "motion write only");
  endtask
  // fifo off: latest sample shown, z negated, indices still
  task automatic t_polarity();
    fifo_enable = 1'b0;
    send(6'h01);
    repeat (6) @(posedge clk);
    rd(arm_pkg::ADDR_SMP_ZL, 8'hdd, "z low negated");
    rd(arm_pkg::ADDR_SMP_ZH, 8'hcf, "z high negated");
    rd(arm_pkg::ADDR_SMP_XL, 8'h23, "x low fifo off");
    rd(arm_pkg::ADDR_QWRIDX, 8'h23, "write index fifo off");
    rd(arm_pkg::ADDR_QFLAGS, 8'h01, "flags fifo off");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1; reg_wr_en = 1'b0; reg_rd_en = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    wake_state = 1'b1; fifo_enable = 1'b1; start = 1'b0; count = 6'h00;
    det_raw = 5'h00; det_filt = 5'h00;
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    t_reset();
    t_rate();
    t_fifo();
    t_motion();
    t_polarity();
    summarize();
  end
endmodule // testbench
bind arm_regs arm_regs_props props_u (.clk(clk), .srst(srst), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid), .wake_state(wake_state), .fifo_enable(fifo_enable),
  .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data), .det_raw(det_raw),
  .det_filt(det_filt), .output_sample_rate(output_sample_rate), .rate_hz(rate_hz),
  .motion_cfg(motion_cfg), .motion_flags(motion_flags), .queue_empty(queue_empty),
  .queue_full(queue_full), .queue_level_flag(queue_level_flag));
`default_nettype wire
